// ==== hw/eiobp_defines.vh ====
// Constants for the external I/O expansion bus port
`ifndef EIOBP_DEFINES_VH
`define EIOBP_DEFINES_VH

// Processor clock rate in MHz
`define EIOBP_CLOCK_MHZ 100

// Longest recommended wait hold, in microseconds
`define EIOBP_WAIT_LIMIT_US 500
// Wait hold that risks dynamic memory loss, in microseconds
`define EIOBP_WAIT_RISK_US 2000

// Wait figures turned into processor clock cycles
`define EIOBP_WAIT_LIMIT_CYCLES (`EIOBP_WAIT_LIMIT_US * `EIOBP_CLOCK_MHZ)
`define EIOBP_WAIT_RISK_CYCLES (`EIOBP_WAIT_RISK_US * `EIOBP_CLOCK_MHZ)

// Widths of the address and data paths
`define EIOBP_ADDR_WIDTH 8
`define EIOBP_DATA_WIDTH 8

// Address bit that marks the system-reserved port range
`define EIOBP_RESERVED_BIT 7

// Processor cycle kinds seen on the control lines
`define EIOBP_CYC_IDLE   2'b00
`define EIOBP_CYC_INPUT  2'b01
`define EIOBP_CYC_OUTPUT 2'b10
`define EIOBP_CYC_ACK    2'b11

// Reset and idle values of the bus side
`define EIOBP_STROBE_OFF 1'b1
`define EIOBP_DATA_RESET 8'h00
`define EIOBP_SYNC_RESET 11'h7ff

`endif

// ==== hw/eiobp_sync.v ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module eiobp_sync #(
  parameter         WIDTH       = 1,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
  input  wire             clock,
  input  wire             reset,
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);

  reg [WIDTH-1:0] stage;

  // First stage feeds only the second
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      stage <= RESET_VALUE;
      q     <= RESET_VALUE;
    end else begin
      stage <= d;
      q     <= stage;
    end
  end

endmodule

`default_nettype wire

// ==== hw/eiobp_port.v ====
// External I/O expansion bus port, processor clock domain
//
// Function
// - While enabled, the low eight processor address lines go out on the bus.
// - The 8-bit data path joins bus and processor only while enabled.
// - The opcode-fetch marker is forwarded; with the I/O request it is an ack.
// - The low input strobe stands on the bus for a whole I/O input cycle.
// - The low output strobe stands while I/O request and write are both low.
// - A low bus interrupt request goes to the processor when allowed.
// - A low bus wait request reaches the processor wait only while enabled.
// - A low input select turns the data transceiver toward the processor.
// - Address, data and strobes drive only while external I/O is enabled.
// - Bus interrupts pass only while the bus interrupt enable is one.
// - The bus interrupt line level is readable whatever the enable.
// - Bus interrupts use mode 1, so no vector byte is read at acknowledge.
`timescale 1ns/1ps
`default_nettype none
`include "eiobp_defines.vh"

module eiobp_port #(
  parameter integer WAIT_LIMIT_CYCLES = `EIOBP_WAIT_LIMIT_CYCLES,
  parameter integer WAIT_RISK_CYCLES  = `EIOBP_WAIT_RISK_CYCLES,
  parameter integer COUNT_WIDTH       = 18
) (
  input  wire                         clock,
  input  wire                         reset,
  // Software enables from the system port latches
  input  wire                         external_io_enable,
  input  wire                         bus_interrupt_enable,
  // Processor side
  input  wire [`EIOBP_ADDR_WIDTH-1:0] cpu_addr,
  input  wire [`EIOBP_DATA_WIDTH-1:0] cpu_data_out,
  input  wire                         cpu_iorq_n,
  input  wire                         cpu_rd_n,
  input  wire                         cpu_wr_n,
  input  wire                         cpu_m1_n,
  output reg  [`EIOBP_DATA_WIDTH-1:0] cpu_data_in,
  output reg                          cpu_data_in_en,
  output wire                         cpu_wait_n,
  output wire                         cpu_int_n,
  // Status seen by software
  output reg                          bus_interrupt_status,
  output reg                          bus_wait_overlong,
  output reg                          bus_wait_risk,
  output reg                          reserved_select_fault,
  // Edge connector side
  output reg  [`EIOBP_ADDR_WIDTH-1:0] bus_addr,
  output reg                          bus_addr_oe,
  output reg                          bus_m1_n,
  output reg                          bus_iorq_n,
  output reg                          bus_in_n,
  output reg                          bus_out_n,
  output reg                          bus_ctrl_oe,
  output reg                          bus_reset_n,
  output reg  [`EIOBP_DATA_WIDTH-1:0] bus_data_o,
  output reg                          bus_data_oe,
  input  wire [`EIOBP_DATA_WIDTH-1:0] bus_data_i,
  input  wire                         bus_interrupt_request_n,
  input  wire                         bus_wait_request_n,
  input  wire                         external_input_select_n
);

  // Cycle kinds as state codes
  localparam [1:0] CYC_IDLE   = `EIOBP_CYC_IDLE;
  localparam [1:0] CYC_INPUT  = `EIOBP_CYC_INPUT;
  localparam [1:0] CYC_OUTPUT = `EIOBP_CYC_OUTPUT;
  localparam [1:0] CYC_ACK    = `EIOBP_CYC_ACK;

  // Wait thresholds at counter width
  localparam integer LIMIT_M1 = WAIT_LIMIT_CYCLES - 1;
  localparam integer RISK_M1  = WAIT_RISK_CYCLES - 1;

  wire [COUNT_WIDTH-1:0] limit_last;
  wire [COUNT_WIDTH-1:0] risk_last;
  assign limit_last = LIMIT_M1[COUNT_WIDTH-1:0];
  assign risk_last  = RISK_M1[COUNT_WIDTH-1:0];

  // Classify the processor control lines
  function [1:0] cycle_kind;
    input iorq_n;
    input rd_n;
    input wr_n;
    input m1_n;
    begin
      if (iorq_n)
        cycle_kind = CYC_IDLE;
      else if (!m1_n)
        cycle_kind = CYC_ACK;
      else if (!rd_n)
        cycle_kind = CYC_INPUT;
      else if (!wr_n)
        cycle_kind = CYC_OUTPUT;
      else
        cycle_kind = CYC_IDLE;
    end
  endfunction

  // Input cycle claimed by a peripheral's select
  function claim_seen;
    input [1:0] kind;
    input       select;
    begin
      claim_seen = (kind == CYC_INPUT) & select;
    end
  endfunction

  // Synchronised pin inputs
  wire [`EIOBP_DATA_WIDTH-1:0] data_sync;
  wire                         irq_sync_n;
  wire                         wait_sync_n;
  wire                         select_sync_n;
  wire [10:0]                  pin_sync;

  eiobp_sync #(
    .WIDTH       (11),
    .RESET_VALUE (`EIOBP_SYNC_RESET)
  ) u_pin_sync (
    .clock (clock),
    .reset (reset),
    .d     ({bus_data_i, bus_interrupt_request_n,
             bus_wait_request_n, external_input_select_n}),
    .q     (pin_sync)
  );

  assign data_sync     = pin_sync[10:3];
  assign irq_sync_n    = pin_sync[2];
  assign wait_sync_n   = pin_sync[1];
  assign select_sync_n = pin_sync[0];

  // Current and next processor cycle
  reg  [1:0] cycle;
  reg  [1:0] next_cycle;

  // Wait hold counter
  reg  [COUNT_WIDTH-1:0] wait_count;
  reg  [COUNT_WIDTH-1:0] next_wait_count;

  // Qualified requests from the bus
  wire wait_active;
  wire select_active;
  wire reserved_port;
  wire read_bus;

  // Wait and select count only while enabled
  assign wait_active   = external_io_enable & ~wait_sync_n;
  assign select_active = external_io_enable & ~select_sync_n;
  assign reserved_port = cpu_addr[`EIOBP_RESERVED_BIT];

  // Bus data is taken only for a plain input of a user port
  assign read_bus = claim_seen(cycle, select_active)
                    & ~reserved_port;

  // Sampled pins must have seen our drivers off at their one sampling edge, so the
  // processor never takes back its own write data after the turn round
  reg  [1:0] drive_off_hist;
  wire       read_ok;
  assign read_ok = read_bus & drive_off_hist[1];

  // Processor wait and interrupt lines
  assign cpu_wait_n = ~wait_active;
  assign cpu_int_n  = ~(bus_interrupt_enable & ~irq_sync_n);

  // Next cycle kind from the processor lines
  always @* begin
    next_cycle = cycle;
    case (cycle_kind(cpu_iorq_n, cpu_rd_n, cpu_wr_n, cpu_m1_n))
      CYC_INPUT:  next_cycle = CYC_INPUT;
      CYC_OUTPUT: next_cycle = CYC_OUTPUT;
      CYC_ACK:    next_cycle = CYC_ACK;
      CYC_IDLE:   next_cycle = CYC_IDLE;
      default:    next_cycle = CYC_IDLE;
    endcase
  end

  // Saturating count of wait cycles
  always @* begin
    next_wait_count = {COUNT_WIDTH{1'b0}};
    if (wait_active) begin
      if (wait_count == risk_last)
        next_wait_count = wait_count;
      else
        next_wait_count = wait_count + 1'b1;
    end
  end

  // Cycle tracking
  always @(posedge clock or posedge reset) begin
    if (reset)
      cycle <= CYC_IDLE;
    else
      cycle <= next_cycle;
  end

  // Address and strobes onto the edge connector
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      bus_addr    <= `EIOBP_DATA_RESET;
      bus_addr_oe <= 1'b0;
      bus_m1_n    <= `EIOBP_STROBE_OFF;
      bus_iorq_n  <= `EIOBP_STROBE_OFF;
      bus_in_n    <= `EIOBP_STROBE_OFF;
      bus_out_n   <= `EIOBP_STROBE_OFF;
      bus_ctrl_oe <= 1'b0;
    end else begin
      bus_addr_oe <= external_io_enable;
      bus_ctrl_oe <= external_io_enable;
      if (external_io_enable) begin
        bus_addr   <= cpu_addr;
        bus_m1_n   <= cpu_m1_n;
        bus_iorq_n <= ~(next_cycle != CYC_IDLE);
        bus_in_n   <= ~(next_cycle == CYC_INPUT);
        bus_out_n  <= ~(next_cycle == CYC_OUTPUT);
      end else begin
        bus_addr   <= `EIOBP_DATA_RESET;
        bus_m1_n   <= `EIOBP_STROBE_OFF;
        bus_iorq_n <= `EIOBP_STROBE_OFF;
        bus_in_n   <= `EIOBP_STROBE_OFF;
        bus_out_n  <= `EIOBP_STROBE_OFF;
      end
    end
  end

  // Always-driven system reset to the connector
  always @(posedge clock or posedge reset) begin
    if (reset)
      bus_reset_n <= 1'b0;
    else
      bus_reset_n <= 1'b1;
  end

  // Data transceiver toward the bus
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      bus_data_o  <= `EIOBP_DATA_RESET;
      bus_data_oe <= 1'b0;
    end else begin
      // Turned round while a peripheral selects input
      bus_data_oe <= external_io_enable & select_sync_n;
      if (external_io_enable)
        bus_data_o <= cpu_data_out;
      else
        bus_data_o <= `EIOBP_DATA_RESET;
    end
  end

  // History of our bus drivers being off, one entry per sampling edge;
  // the oldest entry lines up with the data now leaving the synchroniser
  always @(posedge clock or posedge reset) begin
    if (reset)
      drive_off_hist <= 2'b00;
    else
      drive_off_hist <= {drive_off_hist[0], ~bus_data_oe};
  end

  // Data transceiver toward the processor
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      cpu_data_in    <= `EIOBP_DATA_RESET;
      cpu_data_in_en <= 1'b0;
    end else begin
      // No vector byte is fetched at acknowledge
      cpu_data_in_en <= read_ok;
      if (read_ok)
        cpu_data_in <= data_sync;
    end
  end

  // Software-visible status
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      bus_interrupt_status  <= 1'b0;
      reserved_select_fault <= 1'b0;
    end else begin
      // Line level, independent of the interrupt enable
      bus_interrupt_status  <= ~irq_sync_n;
      // Pulse when a reserved port is claimed from the bus
      reserved_select_fault <= claim_seen(cycle, select_active)
                               & reserved_port;
    end
  end

  // Wait length monitoring
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      wait_count        <= {COUNT_WIDTH{1'b0}};
      bus_wait_overlong <= 1'b0;
      bus_wait_risk     <= 1'b0;
    end else begin
      wait_count        <= next_wait_count;
      // Flags follow the hold and drop with it
      bus_wait_overlong <= wait_active
                           & (wait_count >= limit_last);
      bus_wait_risk     <= wait_active
                           & (wait_count >= risk_last);
    end
  end

endmodule

`default_nettype wire

// ==== testbench/eiobp_port_properties.sv ====
// Concurrent checks on the expansion port pins
`timescale 1ns/1ps
`default_nettype none
module eiobp_port_properties (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       external_io_enable,
  input wire logic       bus_interrupt_enable,
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_data_out,
  input wire logic       cpu_iorq_n,
  input wire logic       cpu_rd_n,
  input wire logic       cpu_wr_n,
  input wire logic       cpu_m1_n,
  input wire logic       cpu_data_in_en,
  input wire logic       cpu_wait_n,
  input wire logic       cpu_int_n,
  input wire logic       bus_interrupt_status,
  input wire logic [7:0] bus_addr,
  input wire logic       bus_addr_oe,
  input wire logic       bus_m1_n,
  input wire logic       bus_iorq_n,
  input wire logic       bus_in_n,
  input wire logic       bus_out_n,
  input wire logic       bus_ctrl_oe,
  input wire logic [7:0] bus_data_o,
  input wire logic       bus_data_oe,
  input wire logic       bus_interrupt_request_n,
  input wire logic       bus_wait_request_n,
  input wire logic       external_input_select_n
);
  logic in_cyc;
  logic out_cyc;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Enabled processor input and output cycles
  assign in_cyc = external_io_enable && !cpu_iorq_n && !cpu_rd_n && cpu_m1_n;
  assign out_cyc = external_io_enable && !cpu_iorq_n && !cpu_wr_n && cpu_m1_n;
  out_strobe_a: assert property (
    out_cyc |=> !bus_out_n && bus_addr == $past(cpu_addr)
      && bus_data_o == $past(cpu_data_out)) else $error("output cycle");
  in_strobe_a: assert property (
    in_cyc |=> !bus_in_n && !bus_iorq_n && bus_ctrl_oe) else $error("input");
  ack_mark_a: assert property (
    external_io_enable && !cpu_iorq_n && !cpu_m1_n |=> !bus_m1_n && !bus_iorq_n)
    else $error("acknowledge");
  drive_off_a: assert property (
    !external_io_enable |=> !bus_addr_oe && !bus_ctrl_oe && !bus_data_oe
      && bus_in_n && bus_out_n) else $error("drivers on");
  wait_pass_a: assert property (
    (external_io_enable && !bus_wait_request_n) [*3] |-> !cpu_wait_n)
    else $error("wait");
  int_pass_a: assert property (
    (bus_interrupt_enable && !bus_interrupt_request_n) [*3] |-> !cpu_int_n)
    else $error("interrupt");
  int_gate_a: assert property (
    !cpu_int_n |-> bus_interrupt_enable && !$past(bus_interrupt_request_n, 2))
    else $error("interrupt gate");
  irq_status_a: assert property (
    !bus_interrupt_request_n [*4] |-> bus_interrupt_status) else $error("status");
  read_turn_a: assert property (
    (in_cyc && !external_input_select_n && !cpu_addr[7]) [*6]
      |=> cpu_data_in_en) else $error("read");
endmodule
`default_nettype wire

// ==== testbench/eiobp_periph.sv ====
// Peripheral card model on the expansion edge connector
`timescale 1ns/1ps
`default_nettype none
module eiobp_periph #(
  parameter logic [7:0] PORT = 8'h12
) (
  input  wire logic       clock,
  input  wire logic [7:0] bus_addr,
  input  wire logic       bus_addr_oe,
  input  wire logic       bus_ctrl_oe,
  input  wire logic       bus_in_n,
  input  wire logic       bus_out_n,
  input  wire logic [7:0] bus_data_o,
  input  wire logic       bus_data_oe,
  input  wire logic       hold_wait,
  input  wire logic       raise_irq,
  input  wire logic       rogue,
  output var  logic [7:0] bus_data_i,
  output var  logic       external_input_select_n,
  output var  logic       bus_wait_request_n,
  output var  logic       bus_interrupt_request_n
);
  logic [7:0] store = 8'h00;
  logic [7:0] last = 8'h00;
  logic       hit;
  // Decode; a rogue card claims the input select everywhere, even in
  // the system range and while the port is disabled
  assign hit = bus_ctrl_oe && bus_addr_oe && bus_addr == PORT;
  always_comb external_input_select_n = !(rogue || (hit && !bus_in_n));
  // Wait and interrupt straight from the bench; no vector byte
  always_comb bus_wait_request_n = !hold_wait;
  always_comb bus_interrupt_request_n = !raise_irq;
  // Data wire: port, card, or a floating line that toggles
  always_comb begin
    if (bus_data_oe) bus_data_i = bus_data_o;
    else if (!external_input_select_n) bus_data_i = store;
    else bus_data_i = ~last;
  end
  // Latch writes to the card's port
  always @(posedge clock) begin
    last <= bus_data_i;
    if (hit && !bus_out_n) store <= bus_data_o;
  end
endmodule
`default_nettype wire

// ==== testbench/external_io_bus_port_bench.sv ====
// Self-checking bench for the expansion bus port
`timescale 1ns/1ps
`default_nettype none
module external_io_bus_port_bench;
  logic        clock = 0, reset = 1, rogue = 0, hold_wait = 0, raise_irq = 0;
  logic        external_io_enable = 0, bus_interrupt_enable = 0;
  logic [7:0]  cpu_addr = 8'h00, cpu_data_out = 8'h00, a;
  logic        cpu_iorq_n = 1, cpu_rd_n = 1, cpu_wr_n = 1, cpu_m1_n = 1;
  logic [7:0]  cpu_data_in, bus_addr, bus_data_o, bus_data_i;
  logic        cpu_data_in_en, cpu_wait_n, cpu_int_n, bus_interrupt_status;
  logic        bus_wait_overlong, bus_wait_risk, reserved_select_fault;
  logic        bus_addr_oe, bus_m1_n, bus_iorq_n, bus_in_n, bus_out_n;
  logic        bus_ctrl_oe, bus_reset_n, bus_data_oe, seen;
  logic        bus_interrupt_request_n, bus_wait_request_n;
  logic        external_input_select_n;
  int          fail_count = 0, checked = 0, cycles = 0;
  int          model_q[$] = '{0};
  logic [31:0] seed = 32'hf5d1;
  eiobp_port #(.WAIT_LIMIT_CYCLES(20), .WAIT_RISK_CYCLES(40)) i_eiobp_port (
    .clock(clock), .reset(reset), .external_io_enable(external_io_enable),
    .bus_interrupt_enable(bus_interrupt_enable), .cpu_addr(cpu_addr),
    .cpu_data_out(cpu_data_out), .cpu_iorq_n(cpu_iorq_n),
    .cpu_rd_n(cpu_rd_n), .cpu_wr_n(cpu_wr_n), .cpu_m1_n(cpu_m1_n),
    .cpu_data_in(cpu_data_in), .cpu_data_in_en(cpu_data_in_en),
    .cpu_wait_n(cpu_wait_n), .cpu_int_n(cpu_int_n),
    .bus_interrupt_status(bus_interrupt_status),
    .bus_wait_overlong(bus_wait_overlong), .bus_wait_risk(bus_wait_risk),
    .reserved_select_fault(reserved_select_fault), .bus_addr(bus_addr),
    .bus_addr_oe(bus_addr_oe), .bus_m1_n(bus_m1_n), .bus_iorq_n(bus_iorq_n),
    .bus_in_n(bus_in_n), .bus_out_n(bus_out_n), .bus_ctrl_oe(bus_ctrl_oe),
    .bus_reset_n(bus_reset_n), .bus_data_o(bus_data_o),
    .bus_data_oe(bus_data_oe), .bus_data_i(bus_data_i),
    .bus_interrupt_request_n(bus_interrupt_request_n),
    .bus_wait_request_n(bus_wait_request_n),
    .external_input_select_n(external_input_select_n));
  eiobp_periph i_eiobp_periph (
    .clock(clock), .bus_addr(bus_addr), .bus_addr_oe(bus_addr_oe),
    .bus_ctrl_oe(bus_ctrl_oe), .bus_in_n(bus_in_n), .bus_out_n(bus_out_n),
    .bus_data_o(bus_data_o), .bus_data_oe(bus_data_oe),
    .hold_wait(hold_wait), .raise_irq(raise_irq), .rogue(rogue),
    .bus_data_i(bus_data_i),
    .external_input_select_n(external_input_select_n),
    .bus_wait_request_n(bus_wait_request_n),
    .bus_interrupt_request_n(bus_interrupt_request_n));
  always #5 clock = ~clock;
  // Hang guard
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      conclude();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  // Processor lines {iorq, rd, wr, m1} held for n clocks
  task automatic cyc(input logic [3:0] l, input logic [7:0] ad, d, input int n);
    @(negedge clock);
    {cpu_iorq_n, cpu_rd_n, cpu_wr_n, cpu_m1_n} = l;
    cpu_addr = ad;
    cpu_data_out = d;
    repeat (n) @(negedge clock);
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clock);
    chk("reset out", 0, bus_reset_n);
    reset = 0;
    hold_wait = 1;
    rogue = 1;
    cyc(4'b0101, 8'h12, 8'h5a, 3);
    chk("oe off", 0, {bus_addr_oe, bus_ctrl_oe, bus_data_oe});
    chk("reset out", 1, bus_reset_n);
    chk("wait off", 1, cpu_wait_n);
    cyc(4'b0011, 8'h12, 0, 7);
    chk("read off", 0, cpu_data_in_en);
    hold_wait = 0;
    rogue = 0;
    cyc(4'b1111, 8'h00, 8'h00, 2);
    $display("disabled test done");
    external_io_enable = 1;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      a = i[0] ? 8'h12 : {1'b0, seed[14:8]};
      if (a == 8'h12) model_q.push_back(seed[7:0]);
      cyc(4'b0101, a, seed[7:0], 3);
      chk("out strobe", 0, bus_out_n);
      chk("address", a, bus_addr);
      chk("write data", seed[7:0], bus_data_o);
      cyc(4'b0011, 8'h12, 0, 7);
      chk("in strobe", 0, bus_in_n);
      chk("read data", model_q[$], cpu_data_in);
      chk("read en", 1, cpu_data_in_en);
      chk("turn round", 0, bus_data_oe);
    end
    cyc(4'b0110, 8'h12, 0, 3);
    chk("ack lines", 0, {bus_m1_n, bus_iorq_n});
    chk("ack read", 0, cpu_data_in_en);
    $display("transfer test done");
    rogue = 1;
    seen = 0;
    cyc(4'b0011, 8'h80 | seed[7:0], 0, 1);
    repeat (7) begin
      @(negedge clock);
      seen = seen | reserved_select_fault;
      chk("reserved read", 0, cpu_data_in_en);
    end
    chk("fault seen", 1, seen);
    rogue = 0;
    cyc(4'b1111, 0, 0, 2);
    $display("reserved test done");
    raise_irq = 1;
    repeat (4) @(negedge clock);
    chk("int masked", 1, cpu_int_n);
    chk("int status", 1, bus_interrupt_status);
    chk("drive on", 1, bus_data_oe);
    bus_interrupt_enable = 1;
    @(negedge clock);
    chk("int passed", 0, cpu_int_n);
    raise_irq = 0;
    repeat (4) @(negedge clock);
    chk("int idle", 1, cpu_int_n);
    chk("status idle", 0, bus_interrupt_status);
    $display("interrupt test done");
    hold_wait = 1;
    repeat (4) @(negedge clock);
    chk("wait on", 0, cpu_wait_n);
    repeat (21) @(negedge clock);
    chk("overlong", 1, bus_wait_overlong);
    chk("risk early", 0, bus_wait_risk);
    repeat (25) @(negedge clock);
    chk("risk", 1, bus_wait_risk);
    external_io_enable = 0;
    #1 chk("wait dropped", 1, cpu_wait_n);
    @(negedge clock);
    hold_wait = 0;
    repeat (3) @(negedge clock);
    chk("flags clear", 0, {bus_wait_overlong, bus_wait_risk});
    $display("wait test done");
    conclude();
  end
endmodule
bind eiobp_port eiobp_port_properties i_eiobp_port_properties (
  .clock(clock), .reset(reset), .external_io_enable(external_io_enable),
  .bus_interrupt_enable(bus_interrupt_enable), .cpu_addr(cpu_addr),
  .cpu_data_out(cpu_data_out), .cpu_iorq_n(cpu_iorq_n),
  .cpu_rd_n(cpu_rd_n), .cpu_wr_n(cpu_wr_n), .cpu_m1_n(cpu_m1_n),
  .cpu_data_in_en(cpu_data_in_en), .cpu_wait_n(cpu_wait_n),
  .cpu_int_n(cpu_int_n), .bus_interrupt_status(bus_interrupt_status),
  .bus_addr(bus_addr), .bus_addr_oe(bus_addr_oe), .bus_m1_n(bus_m1_n),
  .bus_iorq_n(bus_iorq_n), .bus_in_n(bus_in_n), .bus_out_n(bus_out_n),
  .bus_ctrl_oe(bus_ctrl_oe), .bus_data_o(bus_data_o),
  .bus_data_oe(bus_data_oe),
  .bus_interrupt_request_n(bus_interrupt_request_n),
  .bus_wait_request_n(bus_wait_request_n),
  .external_input_select_n(external_input_select_n));
`default_nettype wire
